/* sysrg_consts.svh */
// Purpose: Offsets, field positions, reset values of the system register bank.
// Assumes: Byte addressed AXI4-Lite slave with 32-bit data.
// Notes: Configuration words arrive from nonvolatile bits on input ports.
`ifndef SYSRG_CONSTS_SVH
`define SYSRG_CONSTS_SVH
`define SYSRG_OFS_SUBRST    12'h000
`define SYSRG_OFS_CACHE     12'h004
`define SYSRG_OFS_WDOG      12'h008
`define SYSRG_OFS_RTCWAKE   12'h00C
`define SYSRG_OFS_MEMCTL    12'h010
`define SYSRG_OFS_LANE0     12'h014
`define SYSRG_OFS_LANE1     12'h018
`define SYSRG_OFS_LANE2     12'h01C
`define SYSRG_OFS_LANE3     12'h020
`define SYSRG_OFS_LOCKSTAT  12'h024
`define SYSRG_OFS_STATUS    12'h028
`define SYSRG_NUM_PROT      9
`define SYSRG_IDX_W         4
`define SYSRG_BIT_PERIPHERAL_DMA      4
`define SYSRG_BIT_TIMER     5
`define SYSRG_BIT_COMM      14
`define SYSRG_BIT_HIGH_PERF_DMA     16
`define SYSRG_BIT_NVM0      0
`define SYSRG_BIT_NVM1      1
`define SYSRG_BIT_SRAM0     2
`define SYSRG_BIT_SRAM1     3
`define SYSRG_KEEP_ALIVE    32'h0001_400F
`define SYSRG_RTC_MASK_LSB  0
`define SYSRG_RESP_OKAY     2'h0
`define SYSRG_RESP_SLVERR   2'h2
`define SYSRG_ZERO_WORD     32'h0000_0000
`endif

/* sysrg_pkg.sv */
// Purpose: Types shared by the system register bank.
// Assumes: Constants come from sysrg_consts.svh.
// Notes: Nothing here is synthesised on its own.
`include "sysrg_consts.svh"
package sysrg_pkg;
	typedef logic [31:0] sysrg_word_t;
	typedef struct packed {
		logic [11:0] addr;
		sysrg_word_t data;
		logic [3:0]  strb;
	} sysrg_wreq_t;
	typedef struct packed {
		sysrg_word_t subrst;
		sysrg_word_t cache;
		sysrg_word_t wdog;
		sysrg_word_t rtcwake;
	} sysrg_ctrl_t;
	typedef enum logic [1:0] {
		SYSRG_W_IDLE = 2'h0,
		SYSRG_W_RESP = 2'h1
	} sysrg_wstate_t;
endpackage : sysrg_pkg

/* sysrg_protbit.sv */
// Purpose: One protectable register word with a lock mask per bit.
// Assumes: Lock mask bit of 1 means unlocked, 0 means locked.
// Notes: Locked bits are forced to the initial value every cycle.
`timescale 1ns/1ps
`include "sysrg_consts.svh"
module sysrg_protbit
	import sysrg_pkg::*;
(
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	input  wire sysrg_word_t init_value,
	input  wire sysrg_word_t unlock_mask,
	input  wire logic        wr_en,
	input  wire sysrg_word_t wr_data,
	input  wire sysrg_word_t wr_bits,
	output      sysrg_word_t value
);
	sysrg_word_t stored;
	logic        loaded;
	sysrg_word_t next_stored;

	always_comb begin
		next_stored = stored;
		if (wr_en) begin
			next_stored = (stored & ~(wr_bits & unlock_mask)) |
				(wr_data & wr_bits & unlock_mask);
		end
	end

	// A plain flop could be upset; locked bits are taken from the initial value, not the flop.
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			stored <= `SYSRG_ZERO_WORD;
			loaded <= 1'b0;
		end else if (!loaded) begin
			stored <= init_value;
			loaded <= 1'b1;
		end else begin
			stored <= next_stored;
		end
	end

	// Locked bits show the configured value regardless of the flop.
	assign value = loaded ? ((stored & unlock_mask) |
		(init_value & ~unlock_mask)) : init_value;

	a_locked_stays: assert property (@(posedge CORE_CLK) disable iff (RST)
		((value & ~unlock_mask) == (init_value & ~unlock_mask)))
		else $error("Locked bit differs from initial value.");
	a_write_lands: assert property (@(posedge CORE_CLK) disable iff (RST)
		(loaded && wr_en && $stable(unlock_mask)) |=>
		((value & $past(wr_bits & unlock_mask)) ==
		($past(wr_data & wr_bits & unlock_mask))))
		else $error("Unlocked write did not land.");
endmodule : sysrg_protbit

/* sysrg_axil.sv */
// Purpose: AXI4-Lite write channel handling for the register bank.
// Assumes: One write and one read outstanding at most.
// Notes: Address and data are taken in either order.
`timescale 1ns/1ps
module sysrg_axil
	import sysrg_pkg::*;
(
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output      logic        awready,
	input  wire sysrg_word_t wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output      logic        wready,
	output      logic        bvalid,
	input  wire logic        bready,
	output      sysrg_wreq_t wreq,
	output      logic        wfire
);
	sysrg_wstate_t wstate;
	logic          have_a;
	logic          have_d;

	assign awready = (wstate == SYSRG_W_IDLE) && !have_a;
	assign wready  = (wstate == SYSRG_W_IDLE) && !have_d;
	assign wfire   = (wstate == SYSRG_W_IDLE) &&
		(have_a || awvalid) && (have_d || wvalid);
	assign bvalid  = (wstate == SYSRG_W_RESP);

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			have_a    <= 1'b0;
			have_d    <= 1'b0;
			wreq      <= '0;
			wstate    <= SYSRG_W_IDLE;
		end else begin
			case (wstate)
				SYSRG_W_IDLE: begin
					if (awvalid && awready) begin
						wreq.addr <= awaddr;
						have_a    <= 1'b1;
					end
					if (wvalid && wready) begin
						wreq.data <= wdata;
						wreq.strb <= wstrb;
						have_d    <= 1'b1;
					end
					if (wfire) begin
						wstate <= SYSRG_W_RESP;
					end
				end
				SYSRG_W_RESP: begin
					have_a <= 1'b0;
					have_d <= 1'b0;
					if (bready) begin
						wstate <= SYSRG_W_IDLE;
					end
				end
				default: wstate <= SYSRG_W_IDLE;
			endcase
		end
	end
endmodule : sysrg_axil

/* sysrg_bank.sv */
// Purpose: System register bank with nonvolatile initial values and locks.
// Assumes: Configuration and lock words are static nonvolatile inputs.
// Notes: Reached over AXI4-Lite; outputs drive sub-block resets.
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sysrg_consts.svh"
module sysrg_bank
	import sysrg_pkg::*;
(
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	input  wire logic        VARIANT_MEMSUB,
	input  wire sysrg_word_t PRESENT_MASK,
	input  wire sysrg_word_t INIT_SUBRST,
	input  wire sysrg_word_t INIT_CACHE,
	input  wire sysrg_word_t INIT_WDOG,
	input  wire sysrg_word_t INIT_RTCWAKE,
	input  wire sysrg_word_t INIT_MEMCTL,
	input  wire sysrg_word_t INIT_LANE0,
	input  wire sysrg_word_t INIT_LANE1,
	input  wire sysrg_word_t INIT_LANE2,
	input  wire sysrg_word_t INIT_LANE3,
	input  wire logic [8:0]  REG_UNLOCK,
	input  wire sysrg_word_t FIELD_UNLOCK_SUBRST,
	input  wire sysrg_word_t FIELD_UNLOCK_RTC,
	input  wire logic [11:0] S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output      logic        S_AXI_AWREADY,
	input  wire sysrg_word_t S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output      logic        S_AXI_WREADY,
	output      logic [1:0]  S_AXI_BRESP,
	output      logic        S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [11:0] S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output      logic        S_AXI_ARREADY,
	output      sysrg_word_t S_AXI_RDATA,
	output      logic [1:0]  S_AXI_RRESP,
	output      logic        S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	output      sysrg_ctrl_t CTRL_OUT,
	output      sysrg_word_t SUBBLOCK_RESET_HOLD,
	output      logic        RTC_WAKE_MASKED
);
	sysrg_wreq_t  wreq;
	logic         wfire;
	sysrg_word_t  init_vals   [`SYSRG_NUM_PROT];
	sysrg_word_t  unlock_vals [`SYSRG_NUM_PROT];
	sysrg_word_t  reg_vals    [`SYSRG_NUM_PROT];
	logic [`SYSRG_NUM_PROT-1:0] reg_sel;
	logic         wr_mapped;
	logic         wr_locked_hit;
	logic [15:0]  refused_count;
	logic         rd_mapped;
	sysrg_word_t  rd_word;
	logic         was_written;

	// Decodes a byte address to a protectable register index, or all ones.
	function automatic logic [`SYSRG_IDX_W-1:0] reg_index(
		input logic [11:0] addr);
		logic [`SYSRG_IDX_W-1:0] idx;
		idx = 4'hF;
		if (addr[1:0] == 2'h0 && addr[11:2] < 10'(`SYSRG_NUM_PROT)) begin
			idx = addr[5:2];
		end
		return idx;
	endfunction : reg_index

	// Expands four byte strobes into a bit mask.
	function automatic sysrg_word_t strb_bits(input logic [3:0] strb);
		sysrg_word_t m;
		m = `SYSRG_ZERO_WORD;
		for (int b = 0; b < 4; b++) begin
			m[b*8 +: 8] = {8{strb[b]}};
		end
		return m;
	endfunction : strb_bits

	assign init_vals[0] = INIT_SUBRST;
	assign init_vals[1] = INIT_CACHE;
	assign init_vals[2] = INIT_WDOG;
	assign init_vals[3] = INIT_RTCWAKE;
	assign init_vals[4] = INIT_MEMCTL;
	assign init_vals[5] = INIT_LANE0;
	assign init_vals[6] = INIT_LANE1;
	assign init_vals[7] = INIT_LANE2;
	assign init_vals[8] = INIT_LANE3;

	// Register lock and, for words 0 and 3, field lock combine; both must be 1 to write.
	always_comb begin
		for (int i = 0; i < `SYSRG_NUM_PROT; i++) begin
			unlock_vals[i] = {32{REG_UNLOCK[i]}};
		end
		unlock_vals[0] = unlock_vals[0] & FIELD_UNLOCK_SUBRST;
		unlock_vals[3] = unlock_vals[3] & FIELD_UNLOCK_RTC;
	end

	sysrg_axil u_axil (
		.CORE_CLK (CORE_CLK),
		.RST      (RST),
		.awaddr   (S_AXI_AWADDR),
		.awvalid  (S_AXI_AWVALID),
		.awready  (S_AXI_AWREADY),
		.wdata    (S_AXI_WDATA),
		.wstrb    (S_AXI_WSTRB),
		.wvalid   (S_AXI_WVALID),
		.wready   (S_AXI_WREADY),
		.bvalid   (S_AXI_BVALID),
		.bready   (S_AXI_BREADY),
		.wreq     (wreq),
		.wfire    (wfire)
	);

	// The write request is committed one cycle after the handshake.
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			was_written <= 1'b0;
		end else begin
			was_written <= wfire;
		end
	end

	always_comb begin
		reg_sel = '0;
		if (was_written && reg_index(wreq.addr) != 4'hF) begin
			reg_sel[reg_index(wreq.addr)] = 1'b1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `SYSRG_NUM_PROT; g++) begin : g_reg
			sysrg_protbit u_reg (
				.CORE_CLK    (CORE_CLK),
				.RST         (RST),
				.init_value  (init_vals[g]),
				.unlock_mask (unlock_vals[g]),
				.wr_en       (reg_sel[g]),
				.wr_data     (wreq.data),
				.wr_bits     (strb_bits(wreq.strb)),
				.value       (reg_vals[g])
			);
		end
	endgenerate

	assign wr_mapped = reg_index(wreq.addr) != 4'hF ||
		wreq.addr == `SYSRG_OFS_LOCKSTAT || wreq.addr == `SYSRG_OFS_STATUS;
	assign wr_locked_hit = (reg_sel != '0) && ((strb_bits(wreq.strb) &
		~unlock_vals[reg_index(wreq.addr)]) != `SYSRG_ZERO_WORD);

	// Locked writes answer OKAY; only unmapped addresses give an error.
	assign S_AXI_BRESP = wr_mapped ? `SYSRG_RESP_OKAY : `SYSRG_RESP_SLVERR;

	// Counts refused write attempts so software can see lock activity.
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			refused_count <= 16'h0000;
		end else if (wr_locked_hit && refused_count != 16'hFFFF) begin
			refused_count <= refused_count + 16'h0001;
		end
	end

	always_comb begin
		rd_word   = `SYSRG_ZERO_WORD;
		rd_mapped = 1'b1;
		if (reg_index(S_AXI_ARADDR) != 4'hF) begin
			rd_word = reg_vals[reg_index(S_AXI_ARADDR)];
		end else if (S_AXI_ARADDR == `SYSRG_OFS_LOCKSTAT) begin
			rd_word = {23'h000000, REG_UNLOCK};
		end else if (S_AXI_ARADDR == `SYSRG_OFS_STATUS) begin
			rd_word = {15'h0000, VARIANT_MEMSUB, refused_count};
		end else begin
			rd_mapped = 1'b0;
		end
	end

	assign S_AXI_ARREADY = !S_AXI_RVALID;

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= `SYSRG_ZERO_WORD;
			S_AXI_RRESP  <= `SYSRG_RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= rd_word;
			S_AXI_RRESP  <= rd_mapped ? `SYSRG_RESP_OKAY : `SYSRG_RESP_SLVERR;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// The hold pattern is a flop so resets never glitch on decode paths.
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			SUBBLOCK_RESET_HOLD <= ~(`SYSRG_KEEP_ALIVE);
			RTC_WAKE_MASKED     <= 1'b1;
			CTRL_OUT            <= '0;
		end else begin
			SUBBLOCK_RESET_HOLD <= (reg_vals[0] |
				(VARIANT_MEMSUB ? ~PRESENT_MASK : `SYSRG_ZERO_WORD)) &
				~(`SYSRG_KEEP_ALIVE);
			RTC_WAKE_MASKED <= reg_vals[3][`SYSRG_RTC_MASK_LSB];
			CTRL_OUT <= '{reg_vals[0], reg_vals[1], reg_vals[2], reg_vals[3]};
		end
	end

	a_keep_alive: assert property (@(posedge CORE_CLK) disable iff (RST)
		((SUBBLOCK_RESET_HOLD & `SYSRG_KEEP_ALIVE) == `SYSRG_ZERO_WORD))
		else $error("Always-on block held in reset.");
	// Attempts start only once reset was sampled low, so no reset value leaks.
	a_hold_follow: assert property (@(posedge CORE_CLK) disable iff (RST)
		!RST |=> (SUBBLOCK_RESET_HOLD[8] == $past(reg_vals[0][8]) ||
		($past(VARIANT_MEMSUB) && !$past(PRESENT_MASK[8]))))
		else $error("Reset hold does not follow control.");
	a_absent_held: assert property (@(posedge CORE_CLK) disable iff (RST)
		(VARIANT_MEMSUB && !PRESENT_MASK[9]) |=> SUBBLOCK_RESET_HOLD[9])
		else $error("Absent sub-block not held in reset.");
	a_refused_ok: assert property (@(posedge CORE_CLK) disable iff (RST)
		(wr_locked_hit && reg_sel != '0) |-> S_AXI_BRESP == 2'h0)
		else $error("Locked write answered with an error.");
	a_read_after: assert property (@(posedge CORE_CLK) disable iff (RST)
		(S_AXI_ARVALID && S_AXI_ARREADY) |=> S_AXI_RVALID [*1])
		else $error("Read answer missing.");
	a_rtc_mask: assert property (@(posedge CORE_CLK) disable iff (RST)
		(!unlock_vals[3][`SYSRG_RTC_MASK_LSB] &&
		$stable(unlock_vals[3])) |=>
		RTC_WAKE_MASKED == $past(INIT_RTCWAKE[0], 2) || $past(RST, 2))
		else $error("Locked wakeup mask changed.");
	// A write is taken, committed once, answered, then the slave is idle.
	sequence s_commit;
		was_written ##1 !was_written;
	endsequence
	sequence s_write_done;
		S_AXI_BVALID && S_AXI_BREADY;
	endsequence
	sequence s_write_idle;
		!S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY;
	endsequence
	a_commit_once: assert property (@(posedge CORE_CLK) disable iff (RST)
		wfire |=> s_commit)
		else $error("Write commit pulse is wrong.");
	a_write_close: assert property (@(posedge CORE_CLK) disable iff (RST)
		s_write_done |=> s_write_idle)
		else $error("Write answer did not close.");
	a_count_step: assert property (@(posedge CORE_CLK) disable iff (RST)
		(wr_locked_hit && refused_count != 16'hFFFF) |=>
		refused_count == $past(refused_count) + 16'h0001)
		else $error("Refused write was not counted.");
	a_lock_read: assert property (@(posedge CORE_CLK) disable iff (RST)
		(S_AXI_ARVALID && S_AXI_ARREADY &&
		S_AXI_ARADDR == `SYSRG_OFS_LOCKSTAT) |=>
		S_AXI_RDATA == {23'h0, $past(REG_UNLOCK)})
		else $error("Lock status read is wrong.");
	a_bad_read: assert property (@(posedge CORE_CLK) disable iff (RST)
		(S_AXI_ARVALID && S_AXI_ARREADY && (S_AXI_ARADDR[1:0] != 2'h0 ||
		S_AXI_ARADDR > `SYSRG_OFS_STATUS)) |=>
		(S_AXI_RRESP == `SYSRG_RESP_SLVERR &&
		S_AXI_RDATA == `SYSRG_ZERO_WORD))
		else $error("Unmapped read not refused.");
endmodule : sysrg_bank

/* sysrg_master.sv */
// Purpose: Bus master model standing in for processor or fabric logic.
// Assumes: AXI4-Lite, one write and one read under way at a time.
// Notes: Released address and data lines flip so stale values never match.
`timescale 1ns/1ps
module sysrg_master
	import sysrg_pkg::*;
(
	input  wire logic        clk,
	output      logic [11:0] awaddr,
	output      logic        awvalid,
	input  wire logic        awready,
	output      sysrg_word_t wdata,
	output      logic [3:0]  wstrb,
	output      logic        wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output      logic        bready,
	output      logic [11:0] araddr,
	output      logic        arvalid,
	input  wire logic        arready,
	input  wire sysrg_word_t rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output      logic        rready
);
	initial begin
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
	end

	task automatic bus_write(input logic [11:0] a, input sysrg_word_t d,
		input logic [3:0] s, output logic [1:0] r);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		forever begin
			@(posedge clk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr  <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata  <= ~d;
			end
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : bus_write

	task automatic bus_read(input logic [11:0] a, output sysrg_word_t d,
		output logic [1:0] r);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		forever begin
			@(posedge clk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr  <= ~a;
			end
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask : bus_read
endmodule : sysrg_master

/* tb_top.sv */
// Purpose: Self-checking bench for the system register bank.
// Assumes: Lock and initial words are static and change only under reset.
// Notes: A shadow copy of the bank predicts every read of the nine protectable words.
`timescale 1ns/1ps
`include "sysrg_consts.svh"
module tb_top
	import sysrg_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        variant = 1'b0;
	sysrg_word_t present = '1;
	sysrg_word_t init_v [9] = '{32'h0000_0100, 32'h0000_00A5, 32'h0000_0001,
		32'h0000_0001, 32'h1234_5678, 32'hA000_0000, 32'hA000_0001,
		32'hA000_0002, 32'hA000_0003};
	logic [8:0]  reg_unl = 9'h01D;
	sysrg_word_t fu_sub = 32'hFFFF_00FF;
	sysrg_word_t fu_rtc = 32'hFFFF_FFFE;
	sysrg_word_t shadow [9];
	logic [11:0] awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, rtc_masked;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	sysrg_word_t wdata, rdata, hold, d;
	sysrg_ctrl_t ctrl;
	logic [1:0]  r;
	int          num_errors = 0;
	int          num_checks = 0;
	int          refused = 0;

	initial begin
		forever #2.5 clk = ~clk;
	end

	sysrg_master m (.clk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready);

	sysrg_bank dut (.CORE_CLK(clk), .RST(rst), .VARIANT_MEMSUB(variant),
		.PRESENT_MASK(present), .INIT_SUBRST(init_v[0]),
		.INIT_CACHE(init_v[1]), .INIT_WDOG(init_v[2]),
		.INIT_RTCWAKE(init_v[3]), .INIT_MEMCTL(init_v[4]),
		.INIT_LANE0(init_v[5]), .INIT_LANE1(init_v[6]),
		.INIT_LANE2(init_v[7]), .INIT_LANE3(init_v[8]),
		.REG_UNLOCK(reg_unl), .FIELD_UNLOCK_SUBRST(fu_sub),
		.FIELD_UNLOCK_RTC(fu_rtc), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .CTRL_OUT(ctrl), .SUBBLOCK_RESET_HOLD(hold),
		.RTC_WAKE_MASKED(rtc_masked));

	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out

	task automatic chk(input string what, input sysrg_word_t e,
		input sysrg_word_t g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic chk_resp(input string what, input logic [1:0] e,
		input logic [1:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask : chk_resp

	// The protectable words sit at consecutive word offsets from zero.
	function automatic logic [11:0] adr(input int i);
		return `SYSRG_OFS_SUBRST + 12'(4 * i);
	endfunction : adr

	function automatic sysrg_word_t unl(input int i);
		if (!reg_unl[i]) return '0;
		return (i == 0) ? fu_sub : (i == 3) ? fu_rtc : '1;
	endfunction : unl

	task automatic do_reset;
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		shadow = init_v;
		refused = 0;
		#1;
	endtask : do_reset

	task automatic check_all;
		for (int i = 0; i < 9; i++) begin
			m.bus_read(adr(i), d, r);
			chk_resp("read resp", `SYSRG_RESP_OKAY, r);
			chk($sformatf("reg %0d", i), shadow[i], d);
		end
	endtask : check_all

	task automatic write_all(input sysrg_word_t v, input logic [3:0] s);
		sysrg_word_t bm;
		sysrg_word_t u;
		bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		for (int i = 0; i < 9; i++) begin
			u = unl(i);
			if ((bm & ~u) != '0) refused++;
			m.bus_write(adr(i), v, s, r);
			chk_resp("write resp", `SYSRG_RESP_OKAY, r);
			shadow[i] = (init_v[i] & ~u) | (((shadow[i] & ~bm) | (v & bm)) & u);
		end
	endtask : write_all

	task automatic check_outs;
		#1;
		chk("keep alive", `SYSRG_ZERO_WORD, hold & `SYSRG_KEEP_ALIVE);
		chk("ctrl subrst", shadow[0], ctrl.subrst);
		chk("ctrl cache", shadow[1], ctrl.cache);
		chk("ctrl wdog", shadow[2], ctrl.wdog);
		chk("ctrl rtcwake", shadow[3], ctrl.rtcwake);
		chk("hold", (shadow[0] | (variant ? ~present : '0)) &
			~(`SYSRG_KEEP_ALIVE), hold);
		chk("rtc out", {31'h0, shadow[3][0]}, {31'h0, rtc_masked});
	endtask : check_outs

	initial begin
		#50000;
		num_errors++;
		close_out();
	end

	initial begin
		do_reset();
		check_all();
		check_outs();
		chk("held 8", 32'h1, {31'h0, hold[8]});
		chk("rtc mask", 32'h1, {31'h0, rtc_masked});
		write_all(32'hFFFF_FFFF, 4'hF);
		check_all();
		write_all(32'h0000_0000, 4'h5);
		check_all();
		check_outs();
		chk("held 8 kept", 32'h1, {31'h0, hold[8]});
		chk("rtc mask kept", 32'h1, {31'h0, rtc_masked});
		m.bus_write(`SYSRG_OFS_LOCKSTAT, 32'h0, 4'hF, r);
		chk_resp("lockstat write", `SYSRG_RESP_OKAY, r);
		m.bus_read(`SYSRG_OFS_LOCKSTAT, d, r);
		chk("lockstat", {23'h0, reg_unl}, d);
		m.bus_read(`SYSRG_OFS_STATUS, d, r);
		chk("status", {15'h0, variant, 16'(refused)}, d);
		m.bus_write(12'hFFC, 32'h0, 4'hF, r);
		chk_resp("unmapped write", `SYSRG_RESP_SLVERR, r);
		m.bus_read(12'hFFC, d, r);
		chk_resp("unmapped read", `SYSRG_RESP_SLVERR, r);
		chk("unmapped data", `SYSRG_ZERO_WORD, d);
		@(posedge clk);
		variant <= 1'b1;
		present <= 32'hFFFF_FDFF;
		reg_unl <= 9'h1FF;
		fu_sub  <= '1;
		fu_rtc  <= '1;
		init_v[0] <= 32'h0000_0000;
		do_reset();
		chk("absent held", 32'h1, {31'h0, hold[9]});
		write_all(32'h5A5A_5A5A, 4'hF);
		check_all();
		check_outs();
		m.bus_read(`SYSRG_OFS_STATUS, d, r);
		chk("status end", {15'h0, variant, 16'(refused)}, d);
		close_out();
	end
endmodule : tb_top
